/* hdl/pscs_coex.sv */
// coexistence handshake: medium request, priority and busy gating
`timescale 1ns/10ps
`default_nettype none
module pscs_coex import pscs_pkg::*; (
	input wire logic clk, // clock
	input wire logic rst, // active-high reset
	input wire logic run, // pads released from power-on state
	pscs_coex_if.ctl cx // handshake group
);
	logic req_reg;
	logic pri_reg;
	logic grant_reg;
	// requests registered, priority only with request
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			req_reg <= 1'b0;
			pri_reg <= 1'b0;
			grant_reg <= 1'b0;
		end else begin
			req_reg <= run & cx.req;
			pri_reg <= run & cx.req & cx.hi_pri;
			grant_reg <= run & cx.tx_start & ~cx.busy;
		end
	end
	assign cx.medium_request = req_reg;
	assign cx.high_priority = pri_reg;
	assign cx.grant_tx = grant_reg;
	busy_blocks_a: assert property (@(posedge clk) disable iff (rst)
		cx.busy |=> !grant_reg) else $error("tx start granted while busy");
	pri_needs_req_a: assert property (@(posedge clk) disable iff (rst)
		!(run && cx.req) |=> !pri_reg) else $error("priority without request");
	req_follows_a: assert property (@(posedge clk) disable iff (rst)
		run && cx.req |=> req_reg) else $error("medium request missed");
endmodule // pscs_coex
`default_nettype wire

/* hdl/pscs_coex_if.sv */
// interface carrying coexistence handshake signals
`timescale 1ns/10ps
`default_nettype none
interface pscs_coex_if;
	logic req;
	logic hi_pri;
	logic busy;
	logic tx_start;
	logic grant_tx;
	logic medium_request;
	logic high_priority;
	modport ctl (input req, hi_pri, busy, tx_start, output grant_tx, medium_request,
		high_priority);
	modport top (output req, hi_pri, busy, tx_start, input grant_tx, medium_request,
		high_priority);
endinterface
`default_nettype wire

/* hdl/pscs_pads.sv */
// pad direction, pull and level control for the radio controller pins
`timescale 1ns/10ps
`default_nettype none
`include "pscs_regs.svh"
// Contract
// - request reference clock whenever it is needed
// - power-down input low powers down device
// - medium request asserted for radio tx/rx
// - high priority only together with request
// - no new frame start while medium busy
// - bit clock output in master, input slave
// - frame sync output in master, input slave
// - power-on default pad states as tabulated
// - host wakeup output wakes the host
// - host wakeup off by default, then output
// - indicator enabled and driven after power-on
module pscs_pads import pscs_pkg::*; (
	input wire logic CLK_IN, // 100 MHz clock
	input wire logic RESET_IN, // async reset, high
	input wire logic POWER_DOWN_N_PIN_IN, // power-down pin, low = off
	input wire logic CLK_NEED_IN, // core needs reference clock
	input wire logic CFG_LOAD_IN, // configuration download applied
	input wire logic AUDIO_MASTER_IN, // audio master mode
	input wire logic HOST_WAKE_EN_IN, // host wakeup function enable
	input wire logic HOST_WAKE_REQ_IN, // wake the host
	input wire logic INDICATOR_IN, // indicator level when running
	input wire logic RADIO_REQ_IN, // radio wants medium
	input wire logic RADIO_HI_PRI_IN, // activity is high priority
	input wire logic TX_START_IN, // radio wants to start a frame
	input wire logic COEXIST_MEDIUM_BUSY_IN, // medium busy from wlan
	input wire logic DEVICE_WAKEUP_IN, // wakeup from host
	input wire logic AUD_BCLK_OUT_IN, // internal master bit clock
	input wire logic AUD_SYNC_OUT_IN, // internal master frame sync
	input wire logic AUD_DATA_IN, // internal audio serial out
	input wire logic SER_TX_IN, // internal serial transmit
	input wire logic SER_RTS_IN, // internal request to send
	input wire logic SPARE_IN, // internal spare pin level
	output logic CLK_REQ_OUT, // reference clock request
	output logic TX_GRANT_OUT, // frame start allowed
	output logic POWERED_DOWN_STATE_OUT, // device powered down
	output logic WAKE_PENDING_OUT, // device wakeup seen
	output logic RADIO_MEDIUM_REQUEST_OUT, // coexistence request pin
	output logic RADIO_HIGH_PRIORITY_OUT, // coexistence priority pin
	output logic RADIO_MEDIUM_REQUEST_OE_OUT, // request pin enable
	output logic RADIO_HIGH_PRIORITY_OE_OUT, // priority pin enable
	output logic BCLK_OUT, // audio bit clock level
	output logic BCLK_OE_OUT, // audio bit clock enable
	output logic SYNC_OUT, // audio sync level
	output logic SYNC_OE_OUT, // audio sync enable
	output logic AUD_SER_OUT, // audio serial out level
	output logic AUD_SER_OE_OUT, // audio serial out enable
	output logic SER_TX_OUT, // serial transmit level
	output logic SER_TX_OE_OUT, // serial transmit enable
	output logic SER_RTS_OUT, // request to send level
	output logic SER_RTS_OE_OUT, // request to send enable
	output logic SPARE_OUT, // spare pin level
	output logic SPARE_OE_OUT, // spare pin enable
	output logic HOST_WAKE_OUT, // host wakeup level
	output logic HOST_WAKE_OE_OUT, // host wakeup enable
	output logic ACTIVITY_INDICATOR_OUT, // indicator level
	output logic ACTIVITY_INDICATOR_OE_OUT, // indicator enable
	output logic [1:0] PULL_COEX_OUT, // busy, coex and spare pulls
	output logic [1:0] PULL_AUDIO_IN_OUT, // audio serial in pull
	output logic [1:0] PULL_SER_RX_OUT, // serial receive pull
	output logic [1:0] PULL_CTS_OUT, // clear to send pull
	output logic [1:0] PULL_WAKE_OUT, // both wake lines pull
	output logic [1:0] PULL_OUTS_OUT // pull of pads now inputs
);
	pscs_state_t state_reg, state_next;
	pscs_coex_if cx ();
	logic off;
	logic run;
	logic hw_en_reg;
	logic going_off;
	logic going_run;
	// power-down pin or reset forces off; cfg load leaves defaults
	assign off = ~POWER_DOWN_N_PIN_IN;
	// coex logic silenced on the edge the pin drops, not one later
	assign run = (state_reg == PSCS_RUN) & ~off;
	// state being entered, decoded once for the pad process
	assign going_off = (state_next == PSCS_OFF);
	assign going_run = (state_next == PSCS_RUN);
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			PSCS_OFF: state_next = PSCS_DEFAULT;
			PSCS_DEFAULT: if (CFG_LOAD_IN) state_next = PSCS_RUN;
			PSCS_RUN: state_next = PSCS_RUN;
			default: state_next = PSCS_OFF;
		endcase
		if (off) state_next = PSCS_OFF;
	end
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) state_reg <= PSCS_OFF;
		else state_reg <= state_next;
	end
	// coexistence handshake module
	assign cx.req = RADIO_REQ_IN;
	assign cx.hi_pri = RADIO_HI_PRI_IN;
	assign cx.busy = COEXIST_MEDIUM_BUSY_IN;
	assign cx.tx_start = TX_START_IN;
	pscs_coex u_coex (
		.clk(CLK_IN),
		.rst(RESET_IN),
		.run(run),
		.cx(cx)
	);
	assign RADIO_MEDIUM_REQUEST_OUT = cx.medium_request;
	assign RADIO_HIGH_PRIORITY_OUT = cx.high_priority;
	assign TX_GRANT_OUT = cx.grant_tx;
	// pad drive, enables and pulls by state
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			hw_en_reg <= 1'b0;
			{BCLK_OUT, BCLK_OE_OUT, SYNC_OUT, SYNC_OE_OUT} <= 4'h0;
			{AUD_SER_OUT, AUD_SER_OE_OUT, SER_TX_OUT, SER_TX_OE_OUT} <= 4'h0;
			{SER_RTS_OUT, SER_RTS_OE_OUT, SPARE_OUT, SPARE_OE_OUT} <= 4'h0;
			{HOST_WAKE_OUT, HOST_WAKE_OE_OUT} <= 2'h0;
			{ACTIVITY_INDICATOR_OUT, ACTIVITY_INDICATOR_OE_OUT} <= 2'h0;
			{RADIO_MEDIUM_REQUEST_OE_OUT, RADIO_HIGH_PRIORITY_OE_OUT} <= 2'h0;
			CLK_REQ_OUT <= 1'b0;
			POWERED_DOWN_STATE_OUT <= 1'b1;
			WAKE_PENDING_OUT <= 1'b0;
			PULL_COEX_OUT <= `PSCS_PULL_DOWN;
			PULL_AUDIO_IN_OUT <= `PSCS_PULL_UP;
			PULL_SER_RX_OUT <= `PSCS_PULL_UP;
			PULL_CTS_OUT <= `PSCS_PULL_UP;
			PULL_WAKE_OUT <= `PSCS_PULL_UP;
			PULL_OUTS_OUT <= `PSCS_PULL_UP;
		end else if (going_off) begin
			// all pads input with power-down pulls
			hw_en_reg <= 1'b0;
			{BCLK_OE_OUT, SYNC_OE_OUT, AUD_SER_OE_OUT, SER_TX_OE_OUT} <= 4'h0;
			{SER_RTS_OE_OUT, SPARE_OE_OUT, HOST_WAKE_OE_OUT} <= 3'h0;
			{ACTIVITY_INDICATOR_OE_OUT, RADIO_MEDIUM_REQUEST_OE_OUT} <= 2'h0;
			RADIO_HIGH_PRIORITY_OE_OUT <= 1'b0;
			CLK_REQ_OUT <= 1'b0;
			POWERED_DOWN_STATE_OUT <= 1'b1;
			WAKE_PENDING_OUT <= 1'b0;
			PULL_COEX_OUT <= `PSCS_PULL_DOWN;
			PULL_AUDIO_IN_OUT <= `PSCS_PULL_UP;
			PULL_SER_RX_OUT <= `PSCS_PULL_UP;
			PULL_CTS_OUT <= `PSCS_PULL_UP;
			PULL_WAKE_OUT <= `PSCS_PULL_UP;
			PULL_OUTS_OUT <= `PSCS_PULL_UP;
		end else begin
			POWERED_DOWN_STATE_OUT <= 1'b0;
			CLK_REQ_OUT <= CLK_NEED_IN;
			WAKE_PENDING_OUT <= ~DEVICE_WAKEUP_IN;
			PULL_COEX_OUT <= `PSCS_PULL_DOWN;
			PULL_AUDIO_IN_OUT <= `PSCS_PULL_NONE;
			PULL_SER_RX_OUT <= `PSCS_PULL_NONE;
			PULL_CTS_OUT <= `PSCS_PULL_UP;
			PULL_WAKE_OUT <= `PSCS_PULL_UP;
			PULL_OUTS_OUT <= `PSCS_PULL_NONE;
			{RADIO_MEDIUM_REQUEST_OE_OUT, RADIO_HIGH_PRIORITY_OE_OUT} <= 2'h3;
			{ACTIVITY_INDICATOR_OE_OUT, SPARE_OE_OUT} <= 2'h3;
			{AUD_SER_OE_OUT, SER_TX_OE_OUT, SER_RTS_OE_OUT} <= 3'h7;
			if (going_run) begin
				hw_en_reg <= HOST_WAKE_EN_IN;
				HOST_WAKE_OE_OUT <= HOST_WAKE_EN_IN;
				HOST_WAKE_OUT <= HOST_WAKE_EN_IN & HOST_WAKE_REQ_IN;
				BCLK_OE_OUT <= AUDIO_MASTER_IN;
				BCLK_OUT <= AUDIO_MASTER_IN & AUD_BCLK_OUT_IN;
				SYNC_OE_OUT <= AUDIO_MASTER_IN;
				SYNC_OUT <= AUDIO_MASTER_IN & AUD_SYNC_OUT_IN;
				AUD_SER_OUT <= AUD_DATA_IN;
				SER_TX_OUT <= SER_TX_IN;
				SER_RTS_OUT <= SER_RTS_IN;
				SPARE_OUT <= SPARE_IN;
				ACTIVITY_INDICATOR_OUT <= INDICATOR_IN;
			end else begin
				// power-on defaults held until configured
				hw_en_reg <= 1'b0;
				{HOST_WAKE_OUT, HOST_WAKE_OE_OUT} <= 2'h0;
				{BCLK_OUT, BCLK_OE_OUT, SYNC_OUT, SYNC_OE_OUT} <= 4'h5;
				{AUD_SER_OUT, SER_TX_OUT, SER_RTS_OUT, SPARE_OUT} <= 4'h4;
				ACTIVITY_INDICATOR_OUT <= 1'b1;
			end
		end
	end
	// pad state checks, one edge after the inputs that cause them
	off_all_inputs_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		off |=> !BCLK_OE_OUT && !SER_TX_OE_OUT && !ACTIVITY_INDICATOR_OE_OUT)
		else $error("pad driven in power-down");
	pulls_off_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		off |=> PULL_COEX_OUT == `PSCS_PULL_DOWN && PULL_OUTS_OUT == `PSCS_PULL_UP)
		else $error("power-down pulls wrong");
	coex_off_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		off |=> !TX_GRANT_OUT && !RADIO_MEDIUM_REQUEST_OUT)
		else $error("coexistence output active in power-down");
	default_tx_high_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		state_reg == PSCS_DEFAULT && !off && !CFG_LOAD_IN |=> SER_TX_OUT && SER_TX_OE_OUT)
		else $error("serial transmit not high by default");
	host_wake_off_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		!(HOST_WAKE_EN_IN && going_run) |=> !HOST_WAKE_OE_OUT && !hw_en_reg)
		else $error("host wake driven while off");
	bclk_slave_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		run && !off && !AUDIO_MASTER_IN |=> !BCLK_OE_OUT && !SYNC_OE_OUT)
		else $error("audio clock driven in slave mode");
	clk_req_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		!off && state_reg != PSCS_OFF && CLK_NEED_IN |=> CLK_REQ_OUT)
		else $error("clock request not raised");
	led_default_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		$rose(state_reg == PSCS_DEFAULT) |-> ACTIVITY_INDICATOR_OE_OUT && ACTIVITY_INDICATOR_OUT)
		else $error("indicator not driven after power-on");
	// power-up walk: pin released while off, defaults on the next edge
	sequence leave_off_s;
		state_reg == PSCS_OFF && !off;
	endsequence
	sequence defaults_shown_s;
		!POWERED_DOWN_STATE_OUT && SER_TX_OUT && !BCLK_OUT && BCLK_OE_OUT && !HOST_WAKE_OE_OUT;
	endsequence
	power_up_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		leave_off_s |=> defaults_shown_s) else $error("defaults missing after power-up");
	cfg_sticky_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		state_reg == PSCS_RUN && !off |=> state_reg == PSCS_RUN)
		else $error("configured state lost");
	wake_seen_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		!off && !DEVICE_WAKEUP_IN |=> WAKE_PENDING_OUT)
		else $error("device wakeup missed");
endmodule // pscs_pads
`default_nettype wire

/* hdl/pscs_pkg.sv */
// types for the pad state and coexistence block
package pscs_pkg;
	typedef enum logic [2:0] {
		PSCS_OFF = 3'h1,
		PSCS_DEFAULT = 3'h2,
		PSCS_RUN = 3'h4
	} pscs_state_t;
	typedef logic [1:0] pscs_pull_t;
endpackage

/* hdl/pscs_regs.svh */
// pad state constants for the pad state and coexistence block
`ifndef PSCS_REGS_SVH
`define PSCS_REGS_SVH
`define PSCS_CLK_PERIOD_NS 10
`define PSCS_CLK_STABLE_MS 2
`define PSCS_CLK_STABLE_CYC ((`PSCS_CLK_STABLE_MS * 1000000) / `PSCS_CLK_PERIOD_NS)
`define PSCS_PULL_NONE 2'h0
`define PSCS_PULL_UP 2'h1
`define PSCS_PULL_DOWN 2'h2
`endif

/* verification/pscs_peer_model.sv */
// behavioural wlan device and host driving medium busy and device wakeup
`timescale 1ns/10ps
`default_nettype none
module pscs_peer_model (
	input wire logic clk_in, // bench clock
	input wire logic busy_cmd_in, // make the medium busy
	input wire logic wake_cmd_in, // host wants the device awake
	output logic busy_out, // medium busy level
	output logic wake_n_out // device wakeup, low = wake
);
	// idle: medium free, wakeup line left at its pull-up
	initial begin
		busy_out = 1'h0;
		wake_n_out = 1'h1;
	end
	// lines change just after each edge, never on it
	always @(posedge clk_in) begin
		busy_out <= #1 busy_cmd_in;
		wake_n_out <= #1 ~wake_cmd_in;
	end
endmodule // pscs_peer_model
`default_nettype wire

/* verification/tb.sv */
// self-checking bench for the pad state and coexistence block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
	$display("Error %s exp %h got %h", nm, e, a); end end
module tb;
	logic CLK_IN = 0, RESET_IN = 1, POWER_DOWN_N_PIN_IN = 0, CLK_NEED_IN = 0, CFG_LOAD_IN = 0;
	logic AUDIO_MASTER_IN = 0, HOST_WAKE_EN_IN = 0, HOST_WAKE_REQ_IN = 0, INDICATOR_IN = 0;
	logic RADIO_REQ_IN = 0, RADIO_HI_PRI_IN = 0, TX_START_IN = 0, AUD_BCLK_OUT_IN = 0;
	logic AUD_SYNC_OUT_IN = 0, AUD_DATA_IN = 0, SER_TX_IN = 0, SER_RTS_IN = 0, SPARE_IN = 0;
	logic busy_cmd = 0, wake_cmd = 0;
	wire logic COEXIST_MEDIUM_BUSY_IN, DEVICE_WAKEUP_IN;
	logic CLK_REQ_OUT, TX_GRANT_OUT, POWERED_DOWN_STATE_OUT, WAKE_PENDING_OUT;
	logic RADIO_MEDIUM_REQUEST_OUT, RADIO_HIGH_PRIORITY_OUT, BCLK_OUT, SYNC_OUT, AUD_SER_OUT;
	logic SER_TX_OUT, SER_RTS_OUT, SPARE_OUT, HOST_WAKE_OUT, ACTIVITY_INDICATOR_OUT;
	logic RADIO_MEDIUM_REQUEST_OE_OUT, RADIO_HIGH_PRIORITY_OE_OUT, BCLK_OE_OUT, SYNC_OE_OUT;
	logic AUD_SER_OE_OUT, SER_TX_OE_OUT, SER_RTS_OE_OUT, SPARE_OE_OUT, HOST_WAKE_OE_OUT;
	logic ACTIVITY_INDICATOR_OE_OUT;
	logic [1:0] PULL_COEX_OUT, PULL_AUDIO_IN_OUT, PULL_SER_RX_OUT, PULL_CTS_OUT;
	logic [1:0] PULL_WAKE_OUT, PULL_OUTS_OUT;
	int n_fail = 0, total_checks = 0, cycles = 0;
	// pad groups: request, priority, bclk, sync, aud ser, tx, rts, spare, host wake, led
	wire logic [9:0] oe = {RADIO_MEDIUM_REQUEST_OE_OUT, RADIO_HIGH_PRIORITY_OE_OUT,
		BCLK_OE_OUT, SYNC_OE_OUT, AUD_SER_OE_OUT, SER_TX_OE_OUT, SER_RTS_OE_OUT,
		SPARE_OE_OUT, HOST_WAKE_OE_OUT, ACTIVITY_INDICATOR_OE_OUT};
	wire logic [9:0] lvl = {RADIO_MEDIUM_REQUEST_OUT, RADIO_HIGH_PRIORITY_OUT, BCLK_OUT,
		SYNC_OUT, AUD_SER_OUT, SER_TX_OUT, SER_RTS_OUT, SPARE_OUT, HOST_WAKE_OUT,
		ACTIVITY_INDICATOR_OUT};
	wire logic [11:0] pulls = {PULL_COEX_OUT, PULL_AUDIO_IN_OUT, PULL_SER_RX_OUT,
		PULL_CTS_OUT, PULL_WAKE_OUT, PULL_OUTS_OUT};
	pscs_pads i_dut (
		.CLK_IN(CLK_IN), .RESET_IN(RESET_IN),
		.POWER_DOWN_N_PIN_IN(POWER_DOWN_N_PIN_IN), .CLK_NEED_IN(CLK_NEED_IN),
		.CFG_LOAD_IN(CFG_LOAD_IN), .AUDIO_MASTER_IN(AUDIO_MASTER_IN),
		.HOST_WAKE_EN_IN(HOST_WAKE_EN_IN), .HOST_WAKE_REQ_IN(HOST_WAKE_REQ_IN),
		.INDICATOR_IN(INDICATOR_IN), .RADIO_REQ_IN(RADIO_REQ_IN),
		.RADIO_HI_PRI_IN(RADIO_HI_PRI_IN), .TX_START_IN(TX_START_IN),
		.COEXIST_MEDIUM_BUSY_IN(COEXIST_MEDIUM_BUSY_IN),
		.DEVICE_WAKEUP_IN(DEVICE_WAKEUP_IN), .AUD_BCLK_OUT_IN(AUD_BCLK_OUT_IN),
		.AUD_SYNC_OUT_IN(AUD_SYNC_OUT_IN), .AUD_DATA_IN(AUD_DATA_IN),
		.SER_TX_IN(SER_TX_IN), .SER_RTS_IN(SER_RTS_IN), .SPARE_IN(SPARE_IN),
		.CLK_REQ_OUT(CLK_REQ_OUT), .TX_GRANT_OUT(TX_GRANT_OUT),
		.POWERED_DOWN_STATE_OUT(POWERED_DOWN_STATE_OUT),
		.WAKE_PENDING_OUT(WAKE_PENDING_OUT),
		.RADIO_MEDIUM_REQUEST_OUT(RADIO_MEDIUM_REQUEST_OUT),
		.RADIO_HIGH_PRIORITY_OUT(RADIO_HIGH_PRIORITY_OUT),
		.RADIO_MEDIUM_REQUEST_OE_OUT(RADIO_MEDIUM_REQUEST_OE_OUT),
		.RADIO_HIGH_PRIORITY_OE_OUT(RADIO_HIGH_PRIORITY_OE_OUT),
		.BCLK_OUT(BCLK_OUT), .BCLK_OE_OUT(BCLK_OE_OUT),
		.SYNC_OUT(SYNC_OUT), .SYNC_OE_OUT(SYNC_OE_OUT),
		.AUD_SER_OUT(AUD_SER_OUT), .AUD_SER_OE_OUT(AUD_SER_OE_OUT),
		.SER_TX_OUT(SER_TX_OUT), .SER_TX_OE_OUT(SER_TX_OE_OUT),
		.SER_RTS_OUT(SER_RTS_OUT), .SER_RTS_OE_OUT(SER_RTS_OE_OUT),
		.SPARE_OUT(SPARE_OUT), .SPARE_OE_OUT(SPARE_OE_OUT),
		.HOST_WAKE_OUT(HOST_WAKE_OUT), .HOST_WAKE_OE_OUT(HOST_WAKE_OE_OUT),
		.ACTIVITY_INDICATOR_OUT(ACTIVITY_INDICATOR_OUT),
		.ACTIVITY_INDICATOR_OE_OUT(ACTIVITY_INDICATOR_OE_OUT),
		.PULL_COEX_OUT(PULL_COEX_OUT), .PULL_AUDIO_IN_OUT(PULL_AUDIO_IN_OUT),
		.PULL_SER_RX_OUT(PULL_SER_RX_OUT), .PULL_CTS_OUT(PULL_CTS_OUT),
		.PULL_WAKE_OUT(PULL_WAKE_OUT), .PULL_OUTS_OUT(PULL_OUTS_OUT)
	);
	pscs_peer_model i_peer (.clk_in(CLK_IN), .busy_cmd_in(busy_cmd), .wake_cmd_in(wake_cmd),
		.busy_out(COEXIST_MEDIUM_BUSY_IN), .wake_n_out(DEVICE_WAKEUP_IN));
	// free running clock, stable long before any request
	always #5 CLK_IN = ~CLK_IN;
	// hang guard
	always @(posedge CLK_IN) begin
		cycles++;
		if (cycles == 2000) begin
			n_fail++;
			print_verdict();
		end
	end
	task automatic step(input int n);
		repeat (n) @(posedge CLK_IN);
		#1;
	endtask
	task automatic print_verdict();
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// powered down: every pad an input, coex pulled down, the rest up
	task automatic check_off();
		`CHK("pwd", 1'h1, POWERED_DOWN_STATE_OUT)
		`CHK("oe", 10'h0, oe)
		`CHK("pulls", 12'h955, pulls)
	endtask
	// power-on defaults, held whatever the functional inputs say
	task automatic check_defaults();
		AUDIO_MASTER_IN = 0;
		RADIO_REQ_IN = 1;
		AUD_BCLK_OUT_IN = 1;
		SER_TX_IN = 0;
		step(2);
		`CHK("pwd", 1'h0, POWERED_DOWN_STATE_OUT)
		`CHK("oe", 10'h3fd, oe)
		`CHK("lvl", 10'h011, lvl & 10'h3fd)
		`CHK("led", 1'h1, ACTIVITY_INDICATOR_OUT)
		`CHK("hold", 10'h011, lvl & 10'h3fd)
		`CHK("hwake", 2'h0, {HOST_WAKE_OE_OUT, HOST_WAKE_OUT})
		`CHK("pulls", 10'h205, pulls[11:2])
		CLK_NEED_IN = 1;
		step(2);
		`CHK("clkreq", 1'h1, CLK_REQ_OUT)
		CLK_NEED_IN = 0;
		step(2);
		`CHK("clkreq", 1'h0, CLK_REQ_OUT)
	endtask
	// configuration applied: modes, coexistence and wakeup lines
	task automatic check_run();
		CFG_LOAD_IN = 1;
		step(1);
		CFG_LOAD_IN = 0;
		AUDIO_MASTER_IN = 1;
		AUD_SYNC_OUT_IN = 1;
		RADIO_HI_PRI_IN = 1;
		HOST_WAKE_EN_IN = 1;
		HOST_WAKE_REQ_IN = 1;
		SER_RTS_IN = 1;
		SPARE_IN = 1;
		AUD_DATA_IN = 1;
		step(2);
		`CHK("bclk", 2'h3, {BCLK_OE_OUT, BCLK_OUT})
		`CHK("sync", 2'h3, {SYNC_OE_OUT, SYNC_OUT})
		`CHK("req", 2'h3, {RADIO_MEDIUM_REQUEST_OUT, RADIO_HIGH_PRIORITY_OUT})
		`CHK("hwake", 2'h3, {HOST_WAKE_OE_OUT, HOST_WAKE_OUT})
		`CHK("led", 2'h2, {ACTIVITY_INDICATOR_OE_OUT, ACTIVITY_INDICATOR_OUT})
		`CHK("oe", 10'h3ff, oe)
		`CHK("ser", 4'hb, {AUD_SER_OUT, SER_TX_OUT, SER_RTS_OUT, SPARE_OUT})
		`CHK("pulls", 12'h814, pulls)
		AUDIO_MASTER_IN = 0;
		RADIO_REQ_IN = 0;
		TX_START_IN = 1;
		busy_cmd = 1;
		wake_cmd = 1;
		step(3);
		`CHK("slave", 2'h0, {BCLK_OE_OUT, SYNC_OE_OUT})
		`CHK("pri", 2'h0, {RADIO_MEDIUM_REQUEST_OUT, RADIO_HIGH_PRIORITY_OUT})
		`CHK("grant", 1'h0, TX_GRANT_OUT)
		`CHK("wake", 1'h1, WAKE_PENDING_OUT)
		busy_cmd = 0;
		step(3);
		`CHK("grant", 1'h1, TX_GRANT_OUT)
	endtask
	initial begin
		step(10);
		check_off();
		RESET_IN = 0;
		step(2);
		check_off();
		POWER_DOWN_N_PIN_IN = 1;
		step(3);
		check_defaults();
		check_run();
		POWER_DOWN_N_PIN_IN = 0;
		step(2);
		check_off();
		POWER_DOWN_N_PIN_IN = 1;
		step(3);
		check_defaults();
		print_verdict();
	end
endmodule // tb
`default_nettype wire
